// [logic/two_wire_random_read_slave.sv]
// Two-wire slave: dummy write, repeated start random read, set address
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Overview of operation
// - Device acknowledges a matching address byte and one word address byte; a second gets none.
// - Device acknowledges, then shifts out the addressed byte, MSB first.
// - Stop after word address loads address counter; no data moves.
// - After that stop the device idles until a new start.
// - Next current-address read returns data at the loaded address.
// - First byte holds identifier in upper half, select bits in lower.
// - Device answers to either of two select values.
// - Mismatched address byte gets no acknowledge; rest ignored.
// - After eight bits transmitter releases; receiver pulls low ninth clock.
module two_wire_random_read_slave #(
    parameter int WORDS = twr_pkg::WORDS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Serial bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Storage load port
    input wire twr_pkg::mem_wr_s mem_wr,
    // Status
    output logic [2:0] addr_counter,
    output logic standby
);
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_DEV   = 7'h02,
        ST_ACK   = 7'h04,
        ST_WADDR = 7'h08,
        ST_TX    = 7'h10,
        ST_RACK  = 7'h20,
        ST_IGN   = 7'h40
    } state_e;

    // ==========================================================
    // Pin synchronisers, three stages each
    logic [2:0] scl_sync_reg;
    logic [2:0] sda_sync_reg;
    logic scl_reg;
    logic sda_reg;
    always_ff @(posedge clock) begin
        if (reset) begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
        end else begin
            scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
            sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
        end
    end

    // Filtered levels change only when stages two and three agree
    always_ff @(posedge clock) begin
        if (reset) begin
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
        end else begin
            if (scl_sync_reg[1] == scl_sync_reg[2]) begin
                scl_reg <= scl_sync_reg[2];
            end
            if (sda_sync_reg[1] == sda_sync_reg[2]) begin
                sda_reg <= sda_sync_reg[2];
            end
        end
    end

    logic scl_q;
    logic sda_q;
    always_ff @(posedge clock) begin
        if (reset) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_reg;
            sda_q <= sda_reg;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    assign scl_rise = scl_reg & ~scl_q;
    assign scl_fall = ~scl_reg & scl_q;
    assign start_det = scl_reg & scl_q & sda_q & ~sda_reg;
    assign stop_det = scl_reg & scl_q & ~sda_q & sda_reg;

    // Address byte match on identifier and either select value
    function automatic logic addr_match(input logic [7:0] b);
        logic [2:0] sel;
        sel = b[twr_pkg::SEL_HI:twr_pkg::SEL_LO];
        addr_match = (b[twr_pkg::ID_HI:twr_pkg::ID_LO] == twr_pkg::DEVICE_ID)
            && (sel == twr_pkg::SEL_A || sel == twr_pkg::SEL_B);
    endfunction

    // ==========================================================
    // Storage array, loaded by the write path elsewhere in the device
    logic [7:0] mem [WORDS];
    always_ff @(posedge clock) begin
        if (reset) begin
            for (int i = 0; i < WORDS; i++) begin
                mem[i] <= twr_pkg::STORE_RESET;
            end
        end else if (mem_wr.en) begin
            mem[mem_wr.addr] <= mem_wr.data;
        end
    end

    // ==========================================================
    // Byte engine
    state_e state_reg;
    logic [2:0] bit_reg;
    logic [7:0] shift_reg;
    logic read_reg;
    logic waddr_ok_reg;
    logic [2:0] waddr_reg;
    logic [2:0] counter_reg;
    logic ack_drive_reg;
    logic byte_full_reg;

    always_ff @(posedge clock) begin
        if (reset) begin
            state_reg <= ST_IDLE;
            bit_reg <= 3'h0;
            shift_reg <= 8'h00;
            read_reg <= 1'b0;
            waddr_ok_reg <= 1'b0;
            waddr_reg <= 3'h0;
            counter_reg <= 3'h0;
            ack_drive_reg <= 1'b0;
            byte_full_reg <= 1'b0;
        end else if (start_det) begin
            // Repeated start keeps the captured word address
            state_reg <= ST_DEV;
            bit_reg <= 3'h0;
            byte_full_reg <= 1'b0;
            ack_drive_reg <= 1'b0;
        end else if (stop_det) begin
            if (waddr_ok_reg) begin
                counter_reg <= waddr_reg;
            end
            waddr_ok_reg <= 1'b0;
            ack_drive_reg <= 1'b0;
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE, ST_IGN: begin
                    ack_drive_reg <= 1'b0;
                end
                ST_DEV, ST_WADDR: begin
                    // Count rises: the fall that ends a start is no bit
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_reg};
                        bit_reg <= bit_reg + 3'h1;
                        byte_full_reg <= (bit_reg == twr_pkg::BIT_LAST);
                    end
                    if (scl_fall && byte_full_reg) begin
                        byte_full_reg <= 1'b0;
                        if (state_reg == ST_WADDR) begin
                            waddr_reg <= shift_reg[2:0];
                            waddr_ok_reg <= 1'b1;
                            read_reg <= 1'b0;
                            ack_drive_reg <= 1'b1;
                            state_reg <= ST_ACK;
                        end else if (addr_match(shift_reg)) begin
                            read_reg <= shift_reg[twr_pkg::RW_BIT];
                            waddr_ok_reg <= 1'b0;
                            ack_drive_reg <= 1'b1;
                            state_reg <= ST_ACK;
                        end else begin
                            state_reg <= ST_IGN;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        if (read_reg) begin
                            // Read from counter, set by dummy write or set
                            shift_reg <= mem[counter_reg];
                            ack_drive_reg <= ~mem[counter_reg][7];
                            state_reg <= ST_TX;
                        end else if (waddr_ok_reg) begin
                            // Only one word address byte; wait for Sr/P
                            counter_reg <= waddr_reg;
                            ack_drive_reg <= 1'b0;
                            state_reg <= ST_IGN;
                        end else begin
                            ack_drive_reg <= 1'b0;
                            state_reg <= ST_WADDR;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bit_reg == twr_pkg::BIT_LAST) begin
                            bit_reg <= 3'h0;
                            ack_drive_reg <= 1'b0;
                            state_reg <= ST_RACK;
                        end else begin
                            bit_reg <= bit_reg + 3'h1;
                            ack_drive_reg <= ~shift_reg[6];
                            shift_reg <= {shift_reg[6:0], 1'b0};
                        end
                    end
                end
                ST_RACK: begin
                    ack_drive_reg <= 1'b0;
                    if (scl_fall) begin
                        // Controller ends with no acknowledge and stop
                        state_reg <= ST_IGN;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Open-drain output: only ever pulls low
    always_ff @(posedge clock) begin
        if (reset) begin
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            standby <= 1'b1;
            addr_counter <= 3'h0;
        end else begin
            sda_oe <= ack_drive_reg;
            sda_out <= 1'b0;
            standby <= (state_reg == ST_IDLE);
            addr_counter <= counter_reg;
        end
    end
endmodule
`default_nettype wire

// [logic/twr_pkg.sv]
// Package of constants and types for the two-wire random read slave
package twr_pkg;
    // ==========================================================
    // Address byte layout
    // Device identifier nibble; value arbitrary
    localparam logic [3:0] DEVICE_ID = 4'hA;
    localparam int ID_HI = 7;
    localparam int ID_LO = 4;
    localparam int SEL_HI = 3;
    localparam int SEL_LO = 1;
    localparam int RW_BIT = 0;
    localparam logic [2:0] SEL_A = 3'h0;
    localparam logic [2:0] SEL_B = 3'h1;
    // ==========================================================
    // Storage and byte framing
    localparam int DATA_W = 8;
    localparam int WORDS = 8;
    localparam int WADDR_W = 3;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [7:0] STORE_RESET = 8'h00;
    // ==========================================================
    // Memory write port carrier
    typedef struct packed {
        logic en;
        logic [2:0] addr;
        logic [7:0] data;
    } mem_wr_s;
endpackage

// [test/two_wire_random_read_slave_bench.sv]
// Self-checking bench for the two-wire random read slave
`timescale 1ns/100ps
`default_nettype none
module two_wire_random_read_slave_bench;
    localparam logic [3:0] ID = twr_pkg::DEVICE_ID;
    logic clock, reset, scl, sda_drv, sda_bus, sda_out, sda_oe, standby;
    logic [2:0] addr_counter;
    twr_pkg::mem_wr_s mem_wr;
    logic [7:0] store [8];
    int n_mismatch, tests_run;
    // ==========
    // Wired-and data line with pull-up
    assign sda_bus = sda_drv & ~sda_oe;
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    two_wire_random_read_slave dut (.clock(clock), .reset(reset),
        .scl_in(scl), .sda_in(sda_bus), .sda_out(sda_out), .sda_oe(sda_oe),
        .mem_wr(mem_wr), .addr_counter(addr_counter), .standby(standby));
    twr_master m (.clock(clock), .scl(scl), .sda_drv(sda_drv),
        .sda_bus(sda_bus), .dev_oe(sda_oe));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Dummy write, repeated start, one byte read
    task automatic rd_random(input logic [2:0] sel, input logic [2:0] a);
        logic ack, oe;
        logic [7:0] d;
        m.start();
        m.send_byte({ID, sel, 1'b0}, ack);
        check(8'(ack), 8'h01);
        m.send_byte({5'h00, a}, ack);
        check(8'(ack), 8'h01);
        m.start();
        m.send_byte({ID, sel, 1'b1}, ack);
        check(8'(ack), 8'h01);
        m.recv_byte(1'b1, d, oe);
        check(d, store[a]);
        check(8'(oe), 8'h00);
        check(8'(sda_out), 8'h00);
        m.stop();
    endtask
    // Stop after the word address, then a current-address read
    task automatic set_addr(input logic [2:0] a);
        logic ack, oe;
        logic [7:0] d;
        m.start();
        m.send_byte({ID, twr_pkg::SEL_B, 1'b0}, ack);
        m.send_byte({5'h00, a}, ack);
        m.stop();
        check(8'(addr_counter), 8'(a));
        check(8'(standby), 8'h01);
        m.start();
        m.send_byte({ID, twr_pkg::SEL_A, 1'b1}, ack);
        check(8'(ack), 8'h01);
        m.recv_byte(1'b1, d, oe);
        check(d, store[a]);
        m.stop();
    endtask
    // Foreign address: no answer to it or to what follows
    task automatic bad_addr(input logic [7:0] b);
        logic ack;
        m.start();
        m.send_byte(b, ack);
        check(8'(ack), 8'h00);
        m.send_byte(8'h03, ack);
        check(8'(ack), 8'h00);
        m.stop();
    endtask
    initial begin
        reset = 1'b1;
        mem_wr = '0;
        n_mismatch = 0;
        tests_run = 0;
        repeat (10) @(posedge clock);
        #1;
        reset = 1'b0;
        repeat (6) @(posedge clock);
        #1;
        check({standby, sda_oe, 3'h0, addr_counter}, 8'h80);
        // Distinct word per location so a wrong address shows
        for (int i = 0; i < 8; i++) begin
            store[i] = 8'hA5 + 8'(i) * 8'h3B;
            mem_wr = '{1'b1, 3'(i), store[i]};
            @(posedge clock);
            #1;
        end
        mem_wr.en = 1'b0;
        rd_random(twr_pkg::SEL_A, 3'h7);
        rd_random(twr_pkg::SEL_B, 3'h2);
        set_addr(3'h5);
        bad_addr({ID ^ 4'h1, twr_pkg::SEL_A, 1'b0});
        bad_addr({ID, 3'h2, 1'b0});
        rd_random(twr_pkg::SEL_A, 3'h0);
        summarize();
    end
endmodule
`default_nettype wire

// [test/twr_chk.sv]
// Assertion checker for the two-wire random read slave
`timescale 1ns/100ps
`default_nettype none
module twr_chk (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Serial bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // Storage load and status
    input wire twr_pkg::mem_wr_s mem_wr,
    input wire logic [2:0] addr_counter,
    input wire logic standby
);
    // ==========
    // Properties, all on the one system clock
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    chk_reset_idle: assert property (disable iff (1'b0)
        reset |=> !sda_oe && standby && addr_counter == 3'h0)
        else $error("not idle after reset");
    chk_drain_low: assert property (sda_oe |-> !sda_out)
        else $error("data pin driven high");
    // Moving the pin while the clock is high would fake a start or stop
    chk_oe_scl_low: assert property ($changed(sda_oe) |-> !$past(scl_in, 4))
        else $error("data pin moved with clock high");
    chk_ack_stands: assert property ($rose(sda_oe) |-> sda_oe[*8])
        else $error("low pull too short");
    chk_oe_bounded: assert property ($rose(sda_oe) |-> ##[1:1000] !sda_oe)
        else $error("data pin never released");
    chk_standby_quiet: assert property (standby |-> !sda_oe)
        else $error("driving while in standby");
    chk_counter_idle: assert property (
        standby && $past(standby) |-> $stable(addr_counter))
        else $error("counter moved in standby");
    chk_wake_start: assert property (
        $fell(standby) |-> $past(scl_in, 2) && !$past(sda_in, 2))
        else $error("woke without start");
    // Main scenarios reached
    cover property ($rose(sda_oe));
    cover property ($fell(standby));
    cover property ($rose(standby));
    cover property (mem_wr.en);
endmodule
bind two_wire_random_read_slave twr_chk chk (.clock(clock), .reset(reset),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .mem_wr(mem_wr), .addr_counter(addr_counter), .standby(standby));
`default_nettype wire

// [test/twr_master.sv]
// Behavioural bus controller for the serial clock and data lines
`timescale 1ns/100ps
`default_nettype none
module twr_master (
    // Clock
    input wire logic clock,
    // Serial bus
    output logic scl,
    output logic sda_drv,
    input wire logic sda_bus,
    input wire logic dev_oe
);
    // ==========
    // Idle bus: both lines released, clock stands high
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // Long phases so the synchronisers and filter settle
    task automatic half();
        repeat (12) @(posedge clock);
        #1;
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_drv = b;
        half();
        scl = 1'b1;
        half();
        r = sda_bus;
        scl = 1'b0;
    endtask
    task automatic start();
        sda_drv = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_drv = 1'b0;
        half();
        scl = 1'b0;
    endtask
    task automatic stop();
        sda_drv = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_drv = 1'b1;
        half();
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic recv_byte(input logic nack, output logic [7:0] d,
            output logic oe_ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(nack, r);
        oe_ack = dev_oe;
    endtask
endmodule
`default_nettype wire
